/* rtl/ftbs_pkg.sv */
package ftbs_pkg;
    localparam int ADDR_W     = 17;
    localparam int DATA_W     = 32;
    localparam int LANES      = 4;
    localparam int LANE_W     = 8;
    localparam int BEAT_W     = 2;
    localparam int FIFO_DEPTH = 16;
    // fifo entry layout
    localparam int E_ADV      = 0;
    localparam int E_WR       = 1;
    localparam int E_LANES    = 2;
    localparam int E_PAR      = E_LANES + LANES;
    localparam int E_DATA     = E_PAR + LANES;
    localparam int E_ADDR     = E_DATA + DATA_W;
    localparam int ENTRY_W    = E_ADDR + ADDR_W;

    typedef enum logic [1:0] {
        OP_DESEL,
        OP_READ,
        OP_WRITE
    } ftbs_op_t;
endpackage : ftbs_pkg

/* rtl/ftbs_if.sv */
interface ftbs_if;
    logic                                   clock_gate_n;
    logic                                   chip_select_a_n;
    logic                                   chip_select_b;
    logic                                   chip_select_c_n;
    logic                                   advance_or_load_n;
    logic                                   write_n;
    logic                                   output_drive_n;
    logic [ftbs_pkg::LANES-1:0]             byte_lane_select_n;
    logic [ftbs_pkg::ADDR_W-1:0]            word_address;
    logic [ftbs_pkg::DATA_W-1:0]            dq_dev_o;
    logic [ftbs_pkg::LANES-1:0]             dp_dev_o;
    logic                                   dev_drive;
    logic [ftbs_pkg::DATA_W-1:0]            dq_host_o;
    logic [ftbs_pkg::LANES-1:0]             dp_host_o;
    logic                                   host_oe;
    logic                                   dev_oe;
    logic [ftbs_pkg::DATA_W-1:0]            dq;
    logic [ftbs_pkg::LANES-1:0]             parity_lines;

    // asynchronous output-drive gate on the device side
    assign dev_oe       = dev_drive & ~output_drive_n;
    assign dq           = dev_oe ? dq_dev_o : (host_oe ? dq_host_o : '0);
    assign parity_lines = dev_oe ? dp_dev_o : (host_oe ? dp_host_o : '0);

    modport dev (
        input  clock_gate_n, chip_select_a_n, chip_select_b, chip_select_c_n, advance_or_load_n,
        input  write_n, byte_lane_select_n, word_address, dq, parity_lines,
        output dq_dev_o, dp_dev_o, dev_drive
    );
    modport host (
        output clock_gate_n, chip_select_a_n, chip_select_b, chip_select_c_n, advance_or_load_n,
        output write_n, output_drive_n, byte_lane_select_n, word_address, dq_host_o, dp_host_o, host_oe,
        input  dq, parity_lines, dev_oe
    );
endinterface : ftbs_if

/* rtl/ftbs_fifo.sv */
module ftbs_fifo #(
    parameter int WIDTH = ftbs_pkg::ENTRY_W,
    parameter int DEPTH = ftbs_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    // fill side
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    // drain side
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0]    wr_ptr_reg;
    logic [PW-1:0]    rd_ptr_reg;
    logic [PW:0]      count_reg;
    logic [PW:0]      count_next;
    logic             push;
    logic             pop;

    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;
    assign o_out_data  = mem_reg[rd_ptr_reg];
    assign count_next  = count_reg + (PW+1)'(push) - (PW+1)'(pop);

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            wr_ptr_reg  <= '0;
            rd_ptr_reg  <= '0;
            count_reg   <= '0;
            o_in_ready  <= 1'b0;
            o_out_valid <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_reg <= PW'((32'(wr_ptr_reg) + 1) % DEPTH);
            end
            if (pop) begin
                rd_ptr_reg <= PW'((32'(rd_ptr_reg) + 1) % DEPTH);
            end
            count_reg   <= count_next;
            o_in_ready  <= 32'(count_next) < DEPTH;
            o_out_valid <= count_next != '0;
        end
    end
endmodule : ftbs_fifo

/* rtl/ftbs_device.sv */
module ftbs_device #(
    parameter int ADDR_W = ftbs_pkg::ADDR_W
) (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_reset,
    input  wire logic i_clk_en,
    // strap and status
    input  wire logic i_burst_order,
    output logic      o_selected,
    output logic      o_write_busy,
    // link
    ftbs_if.dev       link
);
    localparam int DW = ftbs_pkg::DATA_W;
    localparam int NL = ftbs_pkg::LANES;
    localparam int LW = ftbs_pkg::LANE_W;
    localparam int BW = ftbs_pkg::BEAT_W;

    logic [DW-1:0]          mem_d [2**ADDR_W];
    logic [NL-1:0]          mem_p [2**ADDR_W];

    ftbs_pkg::ftbs_op_t     state_reg;
    ftbs_pkg::ftbs_op_t     acc_op;
    logic [ADDR_W-1:0]      base_reg;
    logic [BW-1:0]          beat_reg;
    logic [BW-1:0]          beat_next;
    logic [BW-1:0]          low_bits;
    logic [ADDR_W-1:0]      acc_addr;
    logic                   en;
    logic                   load;
    logic                   step;
    logic                   sel;
    logic                   strap_reg;
    logic                   strap_meta_reg;
    logic                   strap_sync_reg;
    logic                   wpend_reg;
    logic [ADDR_W-1:0]      waddr_reg;
    logic [NL-1:0]          wmask_reg;
    logic [DW-1:0]          rd_word;
    logic [NL-1:0]          rd_par;
    logic [DW-1:0]          q_reg;
    logic [NL-1:0]          qp_reg;
    logic                   drive_reg;

    assign en   = i_clk_en & ~link.clock_gate_n;
    assign load = en & ~link.advance_or_load_n;
    assign step = en & link.advance_or_load_n;
    assign sel  = ~link.chip_select_a_n & link.chip_select_b & ~link.chip_select_c_n;

    assign link.dq_dev_o  = q_reg;
    assign link.dp_dev_o  = qp_reg;
    assign link.dev_drive = drive_reg;

    // strap pin brought into the clock domain
    always_ff @(posedge i_clk) begin
        if (i_clk_en) begin
            strap_meta_reg <= i_burst_order;
            strap_sync_reg <= strap_meta_reg;
        end
    end

    // strap taken while in reset, fixed afterwards
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            strap_reg <= strap_sync_reg;
        end
    end

    // access decode for this edge
    always_comb begin
        beat_next = beat_reg + 2'h1;
        if (strap_reg) begin
            low_bits = base_reg[BW-1:0] ^ beat_next;
        end else begin
            low_bits = base_reg[BW-1:0] + beat_next;
        end
        // address of this edge: external on load, counter on step
        if (load) begin
            acc_addr = link.word_address;
            if (!sel) begin
                acc_op = ftbs_pkg::OP_DESEL;
            end else if (link.write_n) begin
                acc_op = ftbs_pkg::OP_READ;
            end else begin
                acc_op = ftbs_pkg::OP_WRITE;
            end
        end else begin
            acc_addr = {base_reg[ADDR_W-1:BW], low_bits};
            acc_op   = state_reg;
        end
    end

    // access state
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_reg <= ftbs_pkg::OP_DESEL;
        end else if (load) begin
            state_reg <= acc_op;
        end
    end

    // burst base
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            base_reg <= '0;
        end else if (load) begin
            base_reg <= link.word_address;
        end
    end

    // burst counter
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            beat_reg <= '0;
        end else if (load) begin
            beat_reg <= '0;
        end else if (step) begin
            beat_reg <= beat_next;
        end
    end

    // read word with forwarding of the write completing this edge
    always_comb begin
        rd_word = mem_d[acc_addr];
        rd_par  = mem_p[acc_addr];
        // a write completing on this edge is not yet in the array
        if (wpend_reg && waddr_reg == acc_addr) begin
            for (int i = 0; i < NL; i++) begin
                if (wmask_reg[i]) begin
                    rd_word[i*LW +: LW] = link.dq[i*LW +: LW];
                    rd_par[i]           = link.parity_lines[i];
                end
            end
        end
    end

    // read data register
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            q_reg  <= '0;
            qp_reg <= '0;
        end else if (en && acc_op == ftbs_pkg::OP_READ) begin
            q_reg  <= rd_word;
            qp_reg <= rd_par;
        end
    end

    // output drive, three-stated unless a read was taken on the last enabled edge (held over gated edges)
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            drive_reg <= 1'b0;
        end else if (en) begin
            if (acc_op == ftbs_pkg::OP_READ) begin
                drive_reg <= 1'b1;
            end else begin
                drive_reg <= 1'b0;
            end
        end
    end

    // write pipeline: address edge, then data edge
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            wpend_reg <= 1'b0;
        end else if (en) begin
            wpend_reg <= acc_op == ftbs_pkg::OP_WRITE;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            waddr_reg <= '0;
            wmask_reg <= '0;
        end else if (en) begin
            waddr_reg <= acc_addr;
            wmask_reg <= ~link.byte_lane_select_n;
        end
    end

    // data phase: lanes came with the address, data now
    always_ff @(posedge i_clk) begin
        if (en && wpend_reg) begin
            for (int i = 0; i < NL; i++) begin
                if (wmask_reg[i]) begin
                    mem_d[waddr_reg][i*LW +: LW] <= link.dq[i*LW +: LW];
                    mem_p[waddr_reg][i]          <= link.parity_lines[i];
                end
            end
        end
    end

    // status
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_selected <= 1'b0;
        end else if (en) begin
            o_selected <= acc_op != ftbs_pkg::OP_DESEL;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_write_busy <= 1'b0;
        end else if (en) begin
            o_write_busy <= acc_op == ftbs_pkg::OP_WRITE;
        end
    end
endmodule : ftbs_device

/* rtl/ftbs_host.sv */
module ftbs_host #(
    parameter int DEPTH = ftbs_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                           i_clk,
    input  wire logic                           i_reset,
    input  wire logic                           i_clk_en,
    input  wire logic                           i_hold,
    // command beats
    input  wire logic                           i_cmd_valid,
    output logic                                o_cmd_ready,
    input  wire logic                           i_cmd_advance,
    input  wire logic                           i_cmd_write,
    input  wire logic [ftbs_pkg::ADDR_W-1:0]    i_cmd_addr,
    input  wire logic [ftbs_pkg::DATA_W-1:0]    i_cmd_data,
    input  wire logic [ftbs_pkg::LANES-1:0]     i_cmd_parity,
    input  wire logic [ftbs_pkg::LANES-1:0]     i_cmd_lanes_n,
    // read results
    output logic                                o_rd_valid,
    output logic [ftbs_pkg::DATA_W-1:0]         o_rd_data,
    output logic [ftbs_pkg::LANES-1:0]          o_rd_parity,
    // link
    ftbs_if.host                                link
);
    localparam int EW = ftbs_pkg::ENTRY_W;

    logic [EW-1:0]          in_entry;
    logic [EW-1:0]          entry;
    logic                   entry_valid;
    logic                   fifo_ready;
    logic                   en;
    logic                   gate_reg;
    ftbs_pkg::ftbs_op_t     kind_reg;
    ftbs_pkg::ftbs_op_t     kind_next;
    ftbs_pkg::ftbs_op_t     dir_reg;
    logic [ftbs_pkg::DATA_W-1:0] bdata_reg;
    logic [ftbs_pkg::LANES-1:0]  bpar_reg;
    logic                   rd_pend_reg;

    assign in_entry = {i_cmd_addr, i_cmd_data, i_cmd_parity, i_cmd_lanes_n, i_cmd_write, i_cmd_advance};
    assign en       = i_clk_en & ~gate_reg;
    assign link.clock_gate_n = gate_reg;
    assign o_cmd_ready = fifo_ready;

    ftbs_fifo #(.WIDTH(EW), .DEPTH(DEPTH)) u_fifo (
        .i_clk       (i_clk),
        .i_reset     (i_reset),
        .i_in_valid  (i_cmd_valid),
        .o_in_ready  (fifo_ready),
        .i_in_data   (in_entry),
        .o_out_valid (entry_valid),
        .i_out_ready (en),
        .o_out_data  (entry)
    );

    always_comb begin
        if (!entry_valid) begin
            kind_next = ftbs_pkg::OP_DESEL;
        end else if (entry[ftbs_pkg::E_ADV]) begin
            kind_next = dir_reg;
        end else begin
            kind_next = entry[ftbs_pkg::E_WR] ? ftbs_pkg::OP_WRITE : ftbs_pkg::OP_READ;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            gate_reg <= 1'b1;
        end else if (i_clk_en) begin
            gate_reg <= i_hold;
        end
    end

    // command pins for the next edge
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            link.chip_select_a_n    <= 1'b1;
            link.chip_select_b      <= 1'b0;
            link.chip_select_c_n    <= 1'b1;
            link.advance_or_load_n  <= 1'b0;
            link.write_n            <= 1'b1;
            link.byte_lane_select_n <= 4'hF;
            link.word_address       <= '0;
            kind_reg                <= ftbs_pkg::OP_DESEL;
            dir_reg                 <= ftbs_pkg::OP_DESEL;
            bdata_reg               <= '0;
            bpar_reg                <= '0;
        end else if (en) begin
            link.chip_select_a_n    <= ~entry_valid;
            link.chip_select_b      <= entry_valid;
            link.chip_select_c_n    <= ~entry_valid;
            link.advance_or_load_n  <= entry_valid & entry[ftbs_pkg::E_ADV];
            link.write_n            <= ~(entry_valid & entry[ftbs_pkg::E_WR]);
            link.byte_lane_select_n <= entry_valid ? entry[ftbs_pkg::E_LANES +: ftbs_pkg::LANES] : 4'hF;
            link.word_address       <= entry[ftbs_pkg::E_ADDR +: ftbs_pkg::ADDR_W];
            kind_reg                <= kind_next;
            bdata_reg               <= entry[ftbs_pkg::E_DATA +: ftbs_pkg::DATA_W];
            bpar_reg                <= entry[ftbs_pkg::E_PAR +: ftbs_pkg::LANES];
            if (!entry_valid || !entry[ftbs_pkg::E_ADV]) begin
                dir_reg <= kind_next;
            end
        end
    end

    // data phase
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            link.host_oe        <= 1'b0;
            link.output_drive_n <= 1'b1;
            link.dq_host_o      <= '0;
            link.dp_host_o      <= '0;
            rd_pend_reg         <= 1'b0;
        end else if (en) begin
            link.host_oe        <= kind_reg == ftbs_pkg::OP_WRITE;
            link.output_drive_n <= kind_reg == ftbs_pkg::OP_WRITE;
            link.dq_host_o      <= bdata_reg;
            link.dp_host_o      <= bpar_reg;
            rd_pend_reg         <= kind_reg == ftbs_pkg::OP_READ;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_rd_valid  <= 1'b0;
            o_rd_data   <= '0;
            o_rd_parity <= '0;
        end else begin
            o_rd_valid <= en & rd_pend_reg;
            if (en && rd_pend_reg) begin
                o_rd_data   <= link.dq;
                o_rd_parity <= link.parity_lines;
            end
        end
    end
endmodule : ftbs_host

/* bench/ftbs_chk.sv */
module ftbs_chk (
    // clock and reset
    input wire logic                        i_clk,
    input wire logic                        i_reset,
    input wire logic                        i_clk_en,
    // link controls
    input wire logic                        clock_gate_n,
    input wire logic                        chip_select_a_n,
    input wire logic                        chip_select_b,
    input wire logic                        chip_select_c_n,
    input wire logic                        advance_or_load_n,
    input wire logic                        write_n,
    // link drive
    input wire logic                        dev_drive,
    input wire logic                        dev_oe,
    input wire logic                        host_oe,
    input wire logic [ftbs_pkg::DATA_W-1:0] dq_dev_o,
    // device status
    input wire logic                        i_selected,
    input wire logic                        i_write_busy
);
    logic               en;
    logic               load;
    logic               sel;
    ftbs_pkg::ftbs_op_t mode_reg;

    assign en   = i_clk_en & ~clock_gate_n;
    assign load = en & ~advance_or_load_n;
    assign sel  = ~chip_select_a_n & chip_select_b & ~chip_select_c_n;

    // direction latched by the last load
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            mode_reg <= ftbs_pkg::OP_DESEL;
        end else if (load) begin
            mode_reg <= !sel ? ftbs_pkg::OP_DESEL : (write_n ? ftbs_pkg::OP_READ : ftbs_pkg::OP_WRITE);
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    a_gate_freeze:
        assert property (!en |=> $stable(dev_drive) && $stable(dq_dev_o) && $stable(i_selected) && $stable(i_write_busy))
        else $error("device drive changed on a gated edge");
    a_read_drive:
        assert property (load && sel && write_n |=> dev_drive)
        else $error("read load did not drive");
    a_read_stands:
        assert property (load && sel && write_n ##1 !en |=> dev_drive)
        else $error("read drive lost over a gated edge");
    a_desel_quiet:
        assert property (load && !sel |=> !dev_drive)
        else $error("deselect load left the bus driven");
    a_write_quiet:
        assert property (load && sel && !write_n |=> !dev_drive && host_oe)
        else $error("write data phase not handed to host");
    a_burst_dir:
        assert property (en && advance_or_load_n |=> dev_drive == (mode_reg == ftbs_pkg::OP_READ))
        else $error("burst step changed direction");
    a_first_quiet:
        assert property (load && sel && mode_reg == ftbs_pkg::OP_DESEL |-> !dev_drive)
        else $error("driven in first clock after deselect");
    a_power_up:
        assert property ($fell(i_reset) |-> !dev_drive && !dev_oe)
        else $error("bus driven after reset");
    a_bus_excl:
        assert property (!(dev_oe && host_oe))
        else $error("both ends drive the bus");
    a_status_sel:
        assert property (en |=> i_selected == (mode_reg != ftbs_pkg::OP_DESEL))
        else $error("selected status disagrees with last load");
    a_status_wr:
        assert property (en |=> i_write_busy == (mode_reg == ftbs_pkg::OP_WRITE))
        else $error("write status disagrees with access direction");
endmodule : ftbs_chk

/* bench/tb_flow_through_burst_sram_ctrl.sv */
module tb_flow_through_burst_sram_ctrl;
    timeunit 1ns;
    timeprecision 1ps;

    logic                        i_clk = 1'b0;
    logic                        i_reset = 1'b1;
    logic                        i_clk_en = 1'b1;
    logic                        i_hold = 1'b1;
    logic                        i_burst_order = 1'b0;
    logic                        cmd_valid = 1'b0;
    logic                        cmd_adv = 1'b0;
    logic                        cmd_wr = 1'b0;
    logic [ftbs_pkg::ADDR_W-1:0] cmd_addr = '0;
    logic [ftbs_pkg::DATA_W-1:0] cmd_data = '0;
    logic [ftbs_pkg::LANES-1:0]  cmd_par = '0;
    logic [ftbs_pkg::LANES-1:0]  cmd_lanes_n = '1;
    logic                        cmd_ready;
    logic                        rd_valid;
    logic [ftbs_pkg::DATA_W-1:0] rd_data;
    logic [ftbs_pkg::LANES-1:0]  rd_par;
    logic                        selected;
    logic                        write_busy;
    int                          error_cnt = 0;
    int                          cmp_count = 0;
    logic [31:0]                 rnd = 32'h9857;
    logic [35:0]                 mem [logic [16:0]];
    logic [35:0]                 exp_q [$];
    logic [16:0]                 base;
    logic [1:0]                  beat;
    logic                        wr_mode;

    always #12.5 i_clk = ~i_clk;

    ftbs_if ftbs_if_i ();
    ftbs_host ftbs_host_i (.i_clk(i_clk), .i_reset(i_reset), .i_clk_en(i_clk_en), .i_hold(i_hold),
        .i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready), .i_cmd_advance(cmd_adv), .i_cmd_write(cmd_wr),
        .i_cmd_addr(cmd_addr), .i_cmd_data(cmd_data), .i_cmd_parity(cmd_par), .i_cmd_lanes_n(cmd_lanes_n),
        .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_rd_parity(rd_par), .link(ftbs_if_i));
    ftbs_device ftbs_device_i (.i_clk(i_clk), .i_reset(i_reset), .i_clk_en(i_clk_en),
        .i_burst_order(i_burst_order), .o_selected(selected), .o_write_busy(write_busy), .link(ftbs_if_i));
    ftbs_chk ftbs_chk_i (.i_clk(i_clk), .i_reset(i_reset), .i_clk_en(i_clk_en),
        .clock_gate_n(ftbs_if_i.clock_gate_n), .chip_select_a_n(ftbs_if_i.chip_select_a_n),
        .chip_select_b(ftbs_if_i.chip_select_b), .chip_select_c_n(ftbs_if_i.chip_select_c_n),
        .advance_or_load_n(ftbs_if_i.advance_or_load_n), .write_n(ftbs_if_i.write_n),
        .dev_drive(ftbs_if_i.dev_drive), .dev_oe(ftbs_if_i.dev_oe), .host_oe(ftbs_if_i.host_oe),
        .dq_dev_o(ftbs_if_i.dq_dev_o), .i_selected(selected), .i_write_busy(write_busy));

    function automatic logic [31:0] next_rnd();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd;
    endfunction : next_rnd

    task automatic summarize();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic cmp(input string what, input logic [35:0] exp, input logic [35:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    // one beat into the fifo, reference memory updated in beat order
    task automatic push(input logic adv, input logic wr, input logic [16:0] addr, input logic [3:0] lanes_n);
        logic [35:0] val;
        logic [35:0] w;
        logic [16:0] eff;
        int          n;
        val[31:0] = next_rnd();
        w[31:0]   = next_rnd();
        val[35:32] = w[3:0];
        for (n = 0; cmd_ready !== 1'b1 && n < 100; n++) begin
            @(negedge i_clk);
        end
        if (n == 100) begin
            error_cnt++;
            summarize();
        end
        cmd_valid   = 1'b1;
        cmd_adv     = adv;
        cmd_wr      = wr;
        cmd_addr    = addr;
        cmd_data    = val[31:0];
        cmd_par     = val[35:32];
        cmd_lanes_n = lanes_n;
        if (!adv) begin
            base    = addr;
            beat    = 2'h0;
            wr_mode = wr;
        end else begin
            beat = beat + 2'h1;
        end
        eff = {base[16:2], i_burst_order ? base[1:0] ^ beat : base[1:0] + beat};
        if (wr_mode) begin
            w = mem.exists(eff) ? mem[eff] : 36'h0;
            for (int l = 0; l < 4; l++) begin
                if (!lanes_n[l]) begin
                    w[8*l +: 8] = val[8*l +: 8];
                    w[32+l]     = val[32+l];
                end
            end
            mem[eff] = w;
        end else begin
            exp_q.push_back(mem[eff]);
        end
        @(negedge i_clk);
    endtask : push

    // write burst, read burst, lane-masked write burst, read burst in one group
    task automatic batch();
        logic [31:0] t;
        logic [16:0] grp;
        t   = next_rnd();
        grp = t[16:0];
        for (int p = 0; p < 16; p++) begin
            t = next_rnd();
            if (p[1:0] == 2'h0) begin
                push(1'b0, !p[2], {grp[16:2], t[1:0]}, (p == 0) ? 4'h0 : t[7:4]);
            end else begin
                push(1'b1, t[8], t[26:10], (p < 4) ? 4'h0 : t[7:4]);
            end
        end
    endtask : batch

    always @(negedge i_clk) begin
        if (!i_reset && rd_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                cmp("rd_valid", 36'h0, 36'h1);
            end else begin
                cmp("rd_word", exp_q.pop_front(), {rd_par, rd_data});
            end
        end
    end

    initial begin
        int          t;
        logic [31:0] r;
        for (int m = 0; m < 2; m++) begin
            i_reset       = 1'b1;
            i_burst_order = m[0];
            repeat (10) @(negedge i_clk);
            i_reset = 1'b0;
            for (int b = 0; b < 4; b++) begin
                i_hold = 1'b1;
                repeat (3) @(negedge i_clk);
                batch();
                cmp("cmd_ready", 36'h0, {35'h0, cmd_ready});
                cmd_valid = 1'b0;
                // drain with random gating and stalls
                for (t = 0; exp_q.size() != 0; t++) begin
                    r        = next_rnd();
                    i_clk_en = |r[1:0];
                    i_hold   = &r[3:2];
                    @(negedge i_clk);
                    if (t == 3000) begin
                        error_cnt++;
                        summarize();
                    end
                end
                i_clk_en = 1'b1;
                i_hold   = 1'b0;
                repeat (8) @(negedge i_clk);
            end
        end
        summarize();
    end
endmodule : tb_flow_through_burst_sram_ctrl
